//--- verilog/ugef_regs.svh
// Functional notes
// - Flag bits 7-6, 2 and 1 read as zero; software writes no ones there.
// - While suspended, non-idle bus signalling sets wake flag bit 5, own resume excluded.
// - Interrupt request is raised while wake flag and its enable are set.
// - End of bus reset sets flag bit 4, held until software clears it.
// - Interrupt request is raised while end-of-reset flag and its enable are set.
// - Each start-of-frame packet identifier sets flag bit 3 until software clears it.
// - Interrupt request is raised while frame-start flag and its enable are set.
// - Bus idle in J state for 3 ms sets suspend flag bit 0, held.
// - Interrupt request is raised while suspend flag and its enable are set.
// - Enable register bits 5, 4, 3, 0 gate flags; reset value 10h.
// - SE0 for at least 3 full-speed bit times is a bus reset; its end is the event.
`ifndef UGEF_REGS_SVH
`define UGEF_REGS_SVH

`define UGEF_FLAG_OFS   8'h00
`define UGEF_EN_OFS     8'h04
`define UGEF_WAKE_BIT   5
`define UGEF_EOR_BIT    4
`define UGEF_SOF_BIT    3
`define UGEF_SUSP_BIT   0
`define UGEF_USED_MASK  8'h39
`define UGEF_FLAG_RST   8'h00
`define UGEF_EN_RST     8'h10
`define UGEF_HSIZE_WORD 3'h2

`define UGEF_CLK_NS     10
`define UGEF_CLK_PS     10000
`define UGEF_BIT_PS     83333
`define UGEF_RESET_BITS 3
`define UGEF_RESET_CYC  ((`UGEF_RESET_BITS * `UGEF_BIT_PS + `UGEF_CLK_PS - 1) / `UGEF_CLK_PS)
`define UGEF_SUSP_MS    3
`define UGEF_SUSP_CYC   (`UGEF_SUSP_MS * 1000000 / `UGEF_CLK_NS)

`endif

//--- verilog/ugef_pkg.sv
package ugef_pkg;

  typedef enum logic [1:0] {
    LS_ACTIVE,
    LS_RESET,
    LS_SUSPEND
  } ugef_lstate_t;

  typedef logic [7:0] ugef_byte_t;

endpackage : ugef_pkg

//--- verilog/ugef_top.sv
// Our own choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/100ps
`include "ugef_regs.svh"

module ugef_top #(
  parameter int SUSP_CYC  = `UGEF_SUSP_CYC,
  parameter int RESET_CYC = `UGEF_RESET_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output      logic [31:0] hrdata,
  output      logic        hreadyout,
  output      logic        hresp,
  input  wire logic        usbDp,
  input  wire logic        usbDm,
  input  wire logic        sofDetect,
  input  wire logic        resumeDrive,
  output      logic        usbIrq,
  output      logic        usbSuspended
);
  import ugef_pkg::*;

  localparam int SW = $clog2(SUSP_CYC + 1);
  localparam int RW = $clog2(RESET_CYC + 1);
  localparam logic [SW-1:0] SUSP_LAST = SW'(SUSP_CYC - 1);
  localparam logic [RW-1:0] RST_LAST  = RW'(RESET_CYC - 1);

  generate
    if (SUSP_CYC < 2 || RESET_CYC < 1) begin : g_bad_param
      $error("ugef_top: SUSP_CYC must be >= 2 and RESET_CYC >= 1");
    end
  endgenerate

  logic [31:0]     hrdata_r;
  logic            hreadyout_r;
  logic            hresp_r;
  logic            usbIrq_r;
  logic            usbSuspended_r;
  logic            wrPend_r;
  logic            rdPend_r;
  logic [7:0]      addr_r;
  ugef_byte_t      flag_r;
  ugef_byte_t      flag_nxt;
  ugef_byte_t      enable_r;
  ugef_byte_t      flagSet;
  ugef_byte_t      flagClr;
  logic [1:0]      lineMeta_r;
  logic [1:0]      lineSync_r;
  ugef_lstate_t    lstate_r;
  logic [RW-1:0]   se0Cnt_r;
  logic [SW-1:0]   idleCnt_r;
  logic            addrPhase;
  logic            wordOk;
  logic            lineJ;
  logic            lineSe0;
  logic            wakeEv;
  logic            eorEv;
  logic            suspEv;

  assign hrdata       = hrdata_r;
  assign hreadyout    = hreadyout_r;
  assign hresp        = hresp_r;
  assign usbIrq       = usbIrq_r;
  assign usbSuspended = usbSuspended_r;

  // Bus slave: writes zero wait, reads one wait so a write just before is seen
  assign addrPhase = hsel && htrans[1] && hready;
  assign wordOk    = (hsize == `UGEF_HSIZE_WORD);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wrPend_r    <= 1'b0;
      rdPend_r    <= 1'b0;
      addr_r      <= 8'h00;
      hreadyout_r <= 1'b1;
    end else if (rdPend_r) begin
      rdPend_r    <= 1'b0;
      hreadyout_r <= 1'b1;
    end else if (addrPhase) begin
      wrPend_r    <= hwrite && wordOk;
      rdPend_r    <= !hwrite;
      addr_r      <= haddr[7:0];
      hreadyout_r <= hwrite;
    end else begin
      wrPend_r    <= 1'b0;
    end
  end

  // Only OKAY is ever answered; unmapped words read zero
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      hresp_r <= 1'b0;
    end else begin
      hresp_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      hrdata_r <= 32'h0000_0000;
    end else if (rdPend_r) begin
      case (addr_r)
        `UGEF_FLAG_OFS: hrdata_r <= {24'h00_0000, flag_r};
        `UGEF_EN_OFS:   hrdata_r <= {24'h00_0000, enable_r};
        default:        hrdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // Reserved positions are masked off so stray ones never stick
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      enable_r <= `UGEF_EN_RST;
    end else if (wrPend_r && addr_r == `UGEF_EN_OFS) begin
      enable_r <= hwdata[7:0] & `UGEF_USED_MASK;
    end
  end

  // Line sampling: pins are asynchronous to core_clk
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      lineMeta_r <= 2'h1;
      lineSync_r <= 2'h1;
    end else begin
      lineMeta_r <= {usbDm, usbDp};
      lineSync_r <= lineMeta_r;
    end
  end

  assign lineJ   = lineSync_r == 2'h1;
  assign lineSe0 = lineSync_r == 2'h0;

  // SE0 length counter, saturating at the reset threshold
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      se0Cnt_r <= '0;
    end else if (!lineSe0) begin
      se0Cnt_r <= '0;
    end else if (se0Cnt_r != RST_LAST) begin
      se0Cnt_r <= se0Cnt_r + 1'b1;
    end
  end

  // Idle J counter; holds at the end, cleared outside LS_ACTIVE so suspend fires once per idle spell
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      idleCnt_r <= '0;
    end else if (!lineJ || lstate_r != LS_ACTIVE) begin
      idleCnt_r <= '0;
    end else if (idleCnt_r != SUSP_LAST) begin
      idleCnt_r <= idleCnt_r + 1'b1;
    end
  end

  // Own upstream resume drives K; that must not look like a host wake
  assign wakeEv = (lstate_r == LS_SUSPEND) && !lineJ && !resumeDrive;
  assign eorEv  = (lstate_r == LS_RESET) && !lineSe0;
  assign suspEv = (lstate_r == LS_ACTIVE) && lineJ && (idleCnt_r == SUSP_LAST);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      lstate_r <= LS_ACTIVE;
    end else begin
      case (lstate_r)
        LS_ACTIVE: begin
          if (lineSe0 && se0Cnt_r == RST_LAST) begin
            lstate_r <= LS_RESET;
          end else if (suspEv) begin
            lstate_r <= LS_SUSPEND;
          end
        end
        LS_RESET: begin
          if (eorEv) begin
            lstate_r <= LS_ACTIVE;
          end
        end
        LS_SUSPEND: begin
          if (wakeEv) begin
            lstate_r <= LS_ACTIVE;
          end
        end
        default: lstate_r <= LS_ACTIVE;
      endcase
    end
  end

  // Next link state folded in so the output keeps the state's timing
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      usbSuspended_r <= 1'b0;
    end else begin
      usbSuspended_r <= suspEv || (lstate_r == LS_SUSPEND && !wakeEv);
    end
  end

  always_comb begin
    flagSet                 = 8'h00;
    flagSet[`UGEF_WAKE_BIT] = wakeEv;
    flagSet[`UGEF_EOR_BIT]  = eorEv;
    flagSet[`UGEF_SOF_BIT]  = sofDetect;
    flagSet[`UGEF_SUSP_BIT] = suspEv;
    flagClr = 8'h00;
    if (wrPend_r && addr_r == `UGEF_FLAG_OFS) begin
      flagClr = hwdata[7:0];
    end
    // Set applied after clear so a coincident event survives
    flag_nxt = ((flag_r & ~flagClr) | flagSet) & `UGEF_USED_MASK;
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      flag_r <= `UGEF_FLAG_RST;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  // Level request, one cycle behind the flags to come straight from a flop
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      usbIrq_r <= 1'b0;
    end else begin
      usbIrq_r <= |(flag_r & enable_r);
    end
  end

  reserved_zero_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (flag_r & ~`UGEF_USED_MASK) == 8'h00 && (enable_r & ~`UGEF_USED_MASK) == 8'h00)
    else $error("reserved flag or enable bit set");

  wake_flag_set_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (lstate_r == LS_SUSPEND && !lineJ && !resumeDrive)
      |=> flag_r[`UGEF_WAKE_BIT] && lstate_r == LS_ACTIVE)
    else $error("wake activity did not set wake flag");

  wake_own_resume_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (lstate_r == LS_SUSPEND && resumeDrive && !flag_r[`UGEF_WAKE_BIT]
      && !(wrPend_r && addr_r == `UGEF_FLAG_OFS))
      |=> !flag_r[`UGEF_WAKE_BIT])
    else $error("own resume set wake flag");

  wake_irq_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (flag_r[`UGEF_WAKE_BIT] && enable_r[`UGEF_WAKE_BIT]) |=> usbIrq_r)
    else $error("wake interrupt missing");

  eor_flag_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (lstate_r == LS_RESET) ##1 (lstate_r == LS_ACTIVE) |-> flag_r[`UGEF_EOR_BIT])
    else $error("end of reset not flagged");

  eor_irq_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (flag_r[`UGEF_EOR_BIT] && enable_r[`UGEF_EOR_BIT]) |=> usbIrq_r)
    else $error("end of reset interrupt missing");

  sof_flag_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    sofDetect |=> flag_r[`UGEF_SOF_BIT])
    else $error("frame start not flagged");

  sof_irq_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (flag_r[`UGEF_SOF_BIT] && enable_r[`UGEF_SOF_BIT]) |=> usbIrq_r)
    else $error("frame start interrupt missing");

  susp_flag_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (lstate_r == LS_ACTIVE && lineJ && idleCnt_r == SUSP_LAST && !lineSe0)
      |=> flag_r[`UGEF_SUSP_BIT] && usbSuspended)
    else $error("idle bus did not raise suspend");

  susp_irq_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (flag_r[`UGEF_SUSP_BIT] && enable_r[`UGEF_SUSP_BIT]) |=> usbIrq_r)
    else $error("suspend interrupt missing");

  irq_quiet_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    ((flag_r & enable_r) == 8'h00) |=> !usbIrq_r)
    else $error("interrupt without enabled flag");

  bus_reset_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (lstate_r == LS_ACTIVE && lineSe0 && se0Cnt_r == RST_LAST) |=> lstate_r == LS_RESET)
    else $error("long SE0 not taken as bus reset");

  set_wins_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (flagSet != 8'h00) |=> (flag_r & $past(flagSet)) == $past(flagSet))
    else $error("hardware set lost to clear");

  wake_hold_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (flag_r[`UGEF_WAKE_BIT] && !flagClr[`UGEF_WAKE_BIT]) |=> flag_r[`UGEF_WAKE_BIT])
    else $error("wake flag dropped without clear");

  eor_hold_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (flag_r[`UGEF_EOR_BIT] && !flagClr[`UGEF_EOR_BIT]) |=> flag_r[`UGEF_EOR_BIT])
    else $error("end of reset flag dropped without clear");

  sof_hold_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (flag_r[`UGEF_SOF_BIT] && !flagClr[`UGEF_SOF_BIT]) |=> flag_r[`UGEF_SOF_BIT])
    else $error("frame start flag dropped without clear");

  susp_hold_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (flag_r[`UGEF_SUSP_BIT] && !flagClr[`UGEF_SUSP_BIT]) |=> flag_r[`UGEF_SUSP_BIT])
    else $error("suspend flag dropped without clear");

  wake_only_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (!flag_r[`UGEF_WAKE_BIT] && lstate_r != LS_SUSPEND) |=> !flag_r[`UGEF_WAKE_BIT])
    else $error("wake flag set outside suspend");

  eor_only_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (!flag_r[`UGEF_EOR_BIT] && lstate_r != LS_RESET) |=> !flag_r[`UGEF_EOR_BIT])
    else $error("end of reset flag set outside reset");

  susp_only_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (!flag_r[`UGEF_SUSP_BIT] && idleCnt_r != SUSP_LAST) |=> !flag_r[`UGEF_SUSP_BIT])
    else $error("suspend flag set before idle time");

  rd_reserved_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    rdPend_r |=> (hrdata_r & ~{24'h00_0000, `UGEF_USED_MASK}) == 32'h0000_0000)
    else $error("reserved read bit not zero");

  en_write_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (wrPend_r && addr_r == `UGEF_EN_OFS)
      |=> {24'h00_0000, enable_r} == ($past(hwdata) & {24'h00_0000, `UGEF_USED_MASK}))
    else $error("enable write not applied");

  susp_state_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    usbSuspended_r == (lstate_r == LS_SUSPEND))
    else $error("suspended output out of step");

endmodule : ugef_top

//--- tb/ugef_host_model.sv
`timescale 1ns/100ps
module ugef_host_model (
  input  wire logic [1:0] lineCmd,
  input  wire logic       sofReq,
  output      logic       usbDp,
  output      logic       usbDm,
  output      logic       sofDetect
);
  // Host drives the pair at all times, so idle is J
  always_comb begin
    case (lineCmd)
      2'h1:    {usbDp, usbDm} = 2'h0;
      2'h2:    {usbDp, usbDm} = 2'h1;
      default: {usbDp, usbDm} = 2'h2;
    endcase
  end
  assign sofDetect = sofReq;
endmodule : ugef_host_model

//--- tb/tb_usb_global_event_flags.sv
`timescale 1ns/100ps
module tb_usb_global_event_flags;
  import ugef_pkg::*;
  localparam int SUSP = 40;
  localparam logic [31:0] ALL = 32'hffffffff;
  localparam logic [31:0] NOSP = 32'hfffffffe;
  logic        core_clk, reset_n, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rdat;
  logic [1:0]  htrans, lineCmd;
  logic [2:0]  hsize;
  logic        usbDp, usbDm, sofDetect, sofReq, resumeDrive, usbIrq, usbSuspended;
  int          err_total = 0;
  int          n_checks  = 0;

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  assign hready = hreadyout;

  // Short idle count keeps the suspend wait brief
  ugef_top #(.SUSP_CYC(SUSP), .RESET_CYC(25)) dut (
    .core_clk(core_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .usbDp(usbDp), .usbDm(usbDm), .sofDetect(sofDetect),
    .resumeDrive(resumeDrive), .usbIrq(usbIrq), .usbSuspended(usbSuspended));
  ugef_host_model host (
    .lineCmd(lineCmd), .sofReq(sofReq), .usbDp(usbDp), .usbDm(usbDm),
    .sofDetect(sofDetect));

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task stop_test;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test

  // Sof pulse may ride the data phase to collide with a clear
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
           input logic sp, output logic [31:0] r);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    if (sp) sofReq <= 1'b1;
    @(posedge core_clk);
    if (sp) sofReq <= 1'b0;
    while (hready !== 1'b1) @(posedge core_clk);
    r = hrdata;
  endtask : ahb

  task wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d, 1'b0, rdat);
  endtask : wr

  task rd(input string nm, input logic [7:0] a, input logic [31:0] m,
          input logic [31:0] e);
    ahb(1'b0, a, 32'h0, 1'b0, rdat);
    chk(nm, rdat & m, e);
  endtask : rd

  task cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc

  initial begin
    #50000;
    err_total++;
    stop_test();
  end

  initial begin
    {reset_n, hsel, hwrite, sofReq, resumeDrive} = 5'h0;
    {haddr, hwdata, htrans, lineCmd} = '0;
    hsize = 3'h2;
    cyc(12);
    reset_n <= 1'b1;
    rd("flags", 8'h00, ALL, 32'h00);
    rd("enable", 8'h04, ALL, 32'h10);
    rd("unmapped", 8'h08, ALL, 32'h00);
    chk("irq", usbIrq, 1'b0);
    $display("test reset values done");
    cyc(SUSP + 10);
    rd("flags", 8'h00, ALL, 32'h01);
    chk("suspended", usbSuspended, 1'b1);
    chk("irq", usbIrq, 1'b0);
    wr(8'h04, 32'h01);
    cyc(2);
    chk("irq", usbIrq, 1'b1);
    rd("enable", 8'h04, ALL, 32'h01);
    $display("test suspend done");
    resumeDrive <= 1'b1;
    lineCmd     <= 2'h2;
    cyc(6);
    rd("flags", 8'h00, ALL, 32'h01);
    resumeDrive <= 1'b0;
    cyc(6);
    rd("flags", 8'h00, ALL, 32'h21);
    chk("suspended", usbSuspended, 1'b0);
    wr(8'h04, 32'h20);
    cyc(2);
    chk("irq", usbIrq, 1'b1);
    wr(8'h00, 32'h01);
    wr(8'h00, 32'h20);
    lineCmd <= 2'h0;
    rd("flags", 8'h00, ALL, 32'h00);
    chk("irq", usbIrq, 1'b0);
    $display("test wake done");
    wr(8'h04, 32'h10);
    lineCmd <= 2'h1;
    cyc(10);
    lineCmd <= 2'h0;
    cyc(4);
    rd("flags", 8'h00, NOSP, 32'h00);
    chk("irq", usbIrq, 1'b0);
    lineCmd <= 2'h1;
    cyc(30);
    lineCmd <= 2'h0;
    cyc(4);
    rd("flags", 8'h00, NOSP, 32'h10);
    chk("irq", usbIrq, 1'b1);
    cyc(8);
    rd("flags", 8'h00, NOSP, 32'h10);
    wr(8'h00, 32'h10);
    rd("flags", 8'h00, NOSP, 32'h00);
    $display("test bus reset done");
    wr(8'h04, 32'h08);
    sofReq <= 1'b1;
    cyc(1);
    sofReq <= 1'b0;
    cyc(2);
    rd("flags", 8'h00, NOSP, 32'h08);
    chk("irq", usbIrq, 1'b1);
    ahb(1'b1, 8'h00, 32'h08, 1'b1, rdat);
    rd("flags", 8'h00, NOSP, 32'h08);
    wr(8'h00, 32'h08);
    rd("flags", 8'h00, NOSP, 32'h00);
    chk("irq", usbIrq, 1'b0);
    chk("hresp", hresp, 1'b0);
    $display("test frame start done");
    reset_n <= 1'b0;
    cyc(2);
    chk("irq", usbIrq, 1'b0);
    reset_n <= 1'b1;
    rd("enable", 8'h04, ALL, 32'h10);
    rd("flags", 8'h00, ALL, 32'h00);
    chk("suspended", usbSuspended, 1'b0);
    $display("test mid-run reset done");
    stop_test();
  end
endmodule : tb_usb_global_event_flags
